// ===== dv/aar_host_model.sv
/*
 Host side model: raises the slotted acknowledgement trigger pin a set
 delay after each frame end event seen while ARM is high. Assumes the receive block on CLOCK.
*/
`timescale 1ns/1ps

module aar_host_model #(
    parameter int SYM_CYCLES = 8
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic ARM,
    input wire logic [7:0] DELAY,
    input wire logic FRAME_DONE_EVENT,
    output logic SLEEP_TX_TRIGGER_PIN
);
    logic [7:0] wait_cnt;
    logic [2:0] hold_cnt;
    logic [7:0] eff_delay;

    // Never earlier than two symbols after frame end
    assign eff_delay = (DELAY < 8'(2 * SYM_CYCLES)) ? 8'(2 * SYM_CYCLES) : DELAY;

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            wait_cnt <= 8'h00;
            hold_cnt <= 3'h0;
            SLEEP_TX_TRIGGER_PIN <= 1'b0;
        end else if (FRAME_DONE_EVENT && ARM) begin
            wait_cnt <= eff_delay;
        end else if (wait_cnt == 8'h01) begin
            wait_cnt <= 8'h00;
            hold_cnt <= 3'h4;
            SLEEP_TX_TRIGGER_PIN <= 1'b1;
        end else begin
            if (wait_cnt != 8'h00) begin
                wait_cnt <= wait_cnt - 8'h01;
            end
            if (hold_cnt != 3'h0) begin
                hold_cnt <= hold_cnt - 3'h1;
            end
            if (hold_cnt == 3'h1) begin
                SLEEP_TX_TRIGGER_PIN <= 1'b0;
            end
        end
    end
endmodule : aar_host_model

// ===== dv/aar_rx_tb.sv
/*
 Self-checking bench for the auto-acknowledge receive block.
 Assumes short symbol counts (8 cycles) and the host model on the trigger pin.
*/
`timescale 1ns/1ps
`include "aar_defines.svh"

module aar_rx_tb;
    import aar_pkg::*;
    logic CLOCK;
    logic SYS_RST;
    logic rx_start;
    logic rx_end;
    logic rx_mode;
    aar_frame_info_t rx_info;
    logic pin;
    logic reg_we;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic done_ev;
    logic match_ev;
    logic ack_start;
    logic ack_ready;
    logic busy;
    logic [2:0] result;
    logic host_arm;
    logic [7:0] host_delay;
    int err_count = 0;
    int num_checks = 0;
    int test_no = 0;

    aar_rx #(.SYM_CYCLES(8), .TRIG_CYCLES(4)) aar_rx_i (
        .CLOCK(CLOCK), .SYS_RST(SYS_RST), .AUTO_ACK_RECEIVE_MODE(rx_mode),
        .RX_START(rx_start), .RX_END(rx_end), .RX_INFO(rx_info),
        .SLEEP_TX_TRIGGER_PIN(pin), .REG_WE(reg_we), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .FRAME_DONE_EVENT(done_ev),
        .ADDR_MATCH_EVENT(match_ev), .ACK_TX_START(ack_start), .ACK_READY(ack_ready),
        .AUTO_ACK_RX_BUSY(busy), .TRANSACTION_RESULT(result)
    );

    aar_host_model #(.SYM_CYCLES(8)) aar_host_model_i (
        .CLOCK(CLOCK), .SYS_RST(SYS_RST), .ARM(host_arm), .DELAY(host_delay),
        .FRAME_DONE_EVENT(done_ev), .SLEEP_TX_TRIGGER_PIN(pin)
    );

    initial begin
        CLOCK = 1'b0;
        forever #10 CLOCK = ~CLOCK;
    end

    task automatic compare(input logic [7:0] got, input logic [7:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : compare

    task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge CLOCK);
        reg_we <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge CLOCK);
        reg_we <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge CLOCK);
        reg_addr <= addr;
        repeat (2) @(posedge CLOCK);
        #1;
        compare(reg_rdata, exp, "register read");
    endtask : reg_read

    // Ack expected at cycle ack after the sampling edge of RX_END; 0 means none
    task automatic run_frame(input logic [7:0] ctrl, input logic slot, input aar_frame_info_t info,
            input logic [7:0] dly, input logic done, input logic match, input logic [7:0] ack);
        int n;
        int rdy;
        int hit;
        reg_write(`AAR_OFS_ACK_CTRL, ctrl);
        reg_write(`AAR_OFS_SLOT_CTRL, {7'h00, slot});
        host_arm <= slot;
        host_delay <= dly;
        @(posedge CLOCK);
        rx_start <= 1'b1;
        @(posedge CLOCK);
        rx_start <= 1'b0;
        rx_end <= 1'b1;
        rx_info <= info;
        #1;
        compare({7'h00, busy}, 8'h01, "busy during frame");
        @(posedge CLOCK);
        rx_end <= 1'b0;
        #1;
        compare({7'h00, busy}, 8'h00, "busy after frame");
        compare({7'h00, done_ev}, {7'h00, done}, "frame end event");
        compare({7'h00, match_ev}, {7'h00, match}, "address match event");
        compare({5'h00, result}, (slot && ack != 0) ? 8'h02 : 8'h00, "wait code");
        @(posedge CLOCK);
        #1;
        n = 1;
        rdy = 0;
        hit = 0;
        while (n < 120 && hit == 0) begin
            if (ack_ready === 1'b1 && rdy == 0) begin
                rdy = n;
            end
            if (ack_start === 1'b1) begin
                hit = n;
            end else begin
                @(posedge CLOCK);
                #1;
                n++;
            end
        end
        compare(8'(hit), ack, "ack start cycle");
        compare(8'(rdy), slot ? 8'd24 : 8'd0, "ack ready cycle");
        compare({5'h00, result}, 8'h00, "result after frame");
        test_no++;
        $display("test %0d finished", test_no);
    endtask : run_frame

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude

    initial begin
        #(20000 * 20);
        err_count++;
        $display("unexpected at %0t: run did not finish", $time);
        conclude();
    end

    initial begin
        SYS_RST = 1'b1;
        rx_start = 1'b0;
        rx_end = 1'b0;
        rx_info = 4'h0;
        reg_we = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        host_arm = 1'b0;
        host_delay = 8'h00;
        rx_mode = 1'b1;
        repeat (6) @(posedge CLOCK);
        SYS_RST <= 1'b0;
        reg_read(`AAR_OFS_ACK_CTRL, `AAR_ACK_CTRL_RST);
        reg_read(`AAR_OFS_SLOT_CTRL, `AAR_SLOT_CTRL_RST);
        reg_read(`AAR_OFS_RADIO_STATE, 8'h00);
        reg_write(8'h55, 8'hff);
        reg_read(8'h55, 8'h00);
        reg_write(`AAR_OFS_RADIO_STATE, 8'hff);
        reg_read(`AAR_OFS_RADIO_STATE, 8'h00);
        reg_write(`AAR_OFS_ACK_CTRL, 8'h34);
        reg_read(`AAR_OFS_ACK_CTRL, 8'h34);
        reg_write(`AAR_OFS_SLOT_CTRL, 8'h01);
        reg_read(`AAR_OFS_SLOT_CTRL, 8'h01);
        $display("register test finished");
        run_frame(8'h00, 1'b0, 4'b0111, 8'd0, 1'b1, 1'b1, 8'd96);
        run_frame(8'h04, 1'b0, 4'b0111, 8'd0, 1'b1, 1'b1, 8'd16);
        run_frame(8'h00, 1'b0, 4'b1111, 8'd0, 1'b0, 1'b0, 8'd0);
        run_frame(8'h20, 1'b0, 4'b1111, 8'd0, 1'b0, 1'b0, 8'd0);
        run_frame(8'h10, 1'b0, 4'b1111, 8'd0, 1'b1, 1'b0, 8'd0);
        run_frame(8'h10, 1'b0, 4'b1110, 8'd0, 1'b0, 1'b0, 8'd0);
        run_frame(8'h34, 1'b0, 4'b1111, 8'd0, 1'b1, 1'b1, 8'd16);
        run_frame(8'h30, 1'b0, 4'b1101, 8'd0, 1'b0, 1'b0, 8'd0);
        run_frame(8'h30, 1'b0, 4'b1011, 8'd0, 1'b1, 1'b1, 8'd0);
        run_frame(8'h30, 1'b0, 4'b1110, 8'd0, 1'b0, 1'b1, 8'd0);
        run_frame(8'h00, 1'b1, 4'b0111, 8'd18, 1'b1, 1'b1, 8'd26);
        run_frame(8'h04, 1'b1, 4'b0111, 8'd60, 1'b1, 1'b1, 8'd68);
        // Strobes outside auto-acknowledge receive mode are ignored
        @(posedge CLOCK);
        rx_mode <= 1'b0;
        rx_start <= 1'b1;
        rx_end <= 1'b1;
        rx_info <= 4'b0111;
        @(posedge CLOCK);
        rx_start <= 1'b0;
        rx_end <= 1'b0;
        #1;
        compare({5'h00, busy, done_ev, match_ev}, 8'h00, "strobes with mode off");
        repeat (2) @(posedge CLOCK);
        #1;
        compare({5'h00, result}, 8'h00, "result with mode off");
        test_no++;
        $display("test %0d finished", test_no);
        conclude();
    end
endmodule : aar_rx_tb

// ===== src/aar_defines.svh
/*
 Register offsets, field positions, reset values, result codes and timing figures
 for the auto-acknowledge receive block. Assumes inclusion by bare name.
*/
`ifndef AAR_DEFINES_SVH
`define AAR_DEFINES_SVH

`define AAR_OFS_RADIO_STATE 8'h02
`define AAR_OFS_ACK_CTRL 8'h17
`define AAR_OFS_SLOT_CTRL 8'h2c

`define AAR_BIT_SHORT_ACK 2
`define AAR_BIT_UPLOAD 4
`define AAR_BIT_FILTER 5
`define AAR_BIT_SLOTTED 0
`define AAR_RESULT_LSB 5

`define AAR_ACK_CTRL_RST 8'h00
`define AAR_SLOT_CTRL_RST 8'h00

`define AAR_RES_SUCCESS 3'h0
`define AAR_RES_WAIT_TRIG 3'h2

`define AAR_CLK_NS 20
`define AAR_SYMBOL_NS 16000
`define AAR_SYM_CYCLES (`AAR_SYMBOL_NS / `AAR_CLK_NS)
`define AAR_TRIG_NS 16000
`define AAR_TRIG_CYCLES (`AAR_TRIG_NS / `AAR_CLK_NS)
`define AAR_STD_ACK_SYM 4'd12
`define AAR_SHORT_ACK_SYM 4'd2
`define AAR_READY_SYM 4'd3
`define AAR_TRIG_MIN_SYM 4'd2

`endif

// ===== src/aar_pkg.sv
/*
 Types shared by the auto-acknowledge receive block.
 Assumes nothing of its surroundings.
*/
package aar_pkg;

    typedef struct packed {
        logic reserved_type;
        logic ack_request;
        logic addr_match;
        logic crc_ok;
    } aar_frame_info_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RX,
        ST_DELAY,
        ST_WAIT_TRIG
    } aar_state_t;

endpackage : aar_pkg

// ===== src/aar_rx.sv
/*
 Auto-acknowledge receive logic: reserved frame type handling, acknowledgement
 start timing (standard, short, slotted) and the registers that steer it.
 Assumes frame start/end strobes and frame info from logic on CLOCK, with
 address match and checksum already evaluated upstream; the trigger pin is
 asynchronous.
*/
// Summary of operation
// - Upload bit accepts reserved type frames
// - Filter bit routes reserved frames through filter
// - Unfiltered: intact reserved frame raises frame end
// - Unfiltered: no address match, no ack
// - Filtered: address filter as data frames
// - Filtered: frame end needs match and intact
// - Filtered: ack needs request and frame end
// - Upload off: reserved frames silently discarded
// - Short bit clear: ack after 12 symbols
// - Short bit set: ack after two symbols
// - Delay choice applies only when slotted is off
// - Slotted bit in slot register enables slotted
// - Slotted: ack waits for trigger rising edge
// - Waiting reports trigger pending result code
// - Slotted: ack ready three symbols after end
// - Ack transmission begins 16 us after trigger
// - Frame end event marks each accepted reception that passes its checks
// - Address match event on matching data frames and filtered reserved frames
`timescale 1ns/1ps
`include "aar_defines.svh"

module aar_rx #(
    parameter int SYM_CYCLES = `AAR_SYM_CYCLES,
    parameter int TRIG_CYCLES = `AAR_TRIG_CYCLES
) (
    input wire logic CLOCK,
    input wire logic SYS_RST,
    input wire logic AUTO_ACK_RECEIVE_MODE,
    input wire logic RX_START,
    input wire logic RX_END,
    input wire aar_pkg::aar_frame_info_t RX_INFO,
    input wire logic SLEEP_TX_TRIGGER_PIN,
    input wire logic REG_WE,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic FRAME_DONE_EVENT,
    output logic ADDR_MATCH_EVENT,
    output logic ACK_TX_START,
    output logic ACK_READY,
    output logic AUTO_ACK_RX_BUSY,
    output logic [2:0] TRANSACTION_RESULT
);
    import aar_pkg::*;

    logic [7:0] auto_ack_extended_control;
    logic [7:0] retry_slot_control;
    logic reserved_type_upload_en;
    logic reserved_type_filter_en;
    logic short_ack_delay_sel;
    logic slotted_en;
    aar_state_t state;
    aar_state_t next_state;
    logic [15:0] cyc_cnt;
    logic [3:0] sym_cnt;
    logic [3:0] target_sym;
    logic sym_tick;
    logic frame_slotted;
    logic trig_s1;
    logic trig_s2;
    logic trig_s3;
    logic trig_edge;
    logic trig_seen;
    logic [15:0] trig_cnt;
    logic take_end;
    logic accept;
    logic done_now;
    logic match_now;
    logic ack_now;
    logic launch;

    function automatic logic [15:0] to16(input int v);
        to16 = v[15:0];
    endfunction : to16

    assign reserved_type_upload_en = auto_ack_extended_control[`AAR_BIT_UPLOAD];
    assign reserved_type_filter_en = auto_ack_extended_control[`AAR_BIT_FILTER];
    assign short_ack_delay_sel = auto_ack_extended_control[`AAR_BIT_SHORT_ACK];
    assign slotted_en = retry_slot_control[`AAR_BIT_SLOTTED];

    // Register writes
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            auto_ack_extended_control <= `AAR_ACK_CTRL_RST;
            retry_slot_control <= `AAR_SLOT_CTRL_RST;
        end else if (REG_WE) begin
            if (REG_ADDR == `AAR_OFS_ACK_CTRL) begin
                auto_ack_extended_control <= REG_WDATA;
            end
            if (REG_ADDR == `AAR_OFS_SLOT_CTRL) begin
                retry_slot_control <= REG_WDATA;
            end
        end
    end

    // Register reads, unmapped offsets return zero
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            REG_RDATA <= 8'h00;
        end else begin
            case (REG_ADDR)
                `AAR_OFS_ACK_CTRL: REG_RDATA <= auto_ack_extended_control;
                `AAR_OFS_SLOT_CTRL: REG_RDATA <= retry_slot_control;
                `AAR_OFS_RADIO_STATE: begin
                    REG_RDATA <= {TRANSACTION_RESULT, 5'h00};
                end
                default: REG_RDATA <= 8'h00;
            endcase
        end
    end

    // Trigger pin synchroniser and edge detect
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            trig_s3 <= 1'b0;
        end else begin
            trig_s1 <= SLEEP_TX_TRIGGER_PIN;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
        end
    end
    assign trig_edge = trig_s2 && !trig_s3;

    // Frame classification at end of reception
    assign take_end = RX_END && AUTO_ACK_RECEIVE_MODE;
    always_comb begin
        accept = 1'b1;
        done_now = RX_INFO.crc_ok && RX_INFO.addr_match;
        match_now = RX_INFO.addr_match;
        ack_now = done_now && RX_INFO.ack_request;
        if (RX_INFO.reserved_type) begin
            if (!reserved_type_upload_en) begin
                accept = 1'b0;
                done_now = 1'b0;
                match_now = 1'b0;
                ack_now = 1'b0;
            end else if (!reserved_type_filter_en) begin
                done_now = RX_INFO.crc_ok;
                match_now = 1'b0;
                ack_now = 1'b0;
            end else begin
                done_now = RX_INFO.crc_ok && RX_INFO.addr_match;
                ack_now = done_now && RX_INFO.ack_request;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            FRAME_DONE_EVENT <= 1'b0;
            ADDR_MATCH_EVENT <= 1'b0;
        end else begin
            FRAME_DONE_EVENT <= take_end && accept && done_now;
            ADDR_MATCH_EVENT <= take_end && accept && match_now;
        end
    end

    // Symbol period timebase, restarted at each frame end
    assign sym_tick = (cyc_cnt == to16(SYM_CYCLES - 1));
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || take_end || sym_tick) begin
            cyc_cnt <= 16'h0000;
        end else begin
            cyc_cnt <= cyc_cnt + 16'h0001;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST || take_end) begin
            sym_cnt <= 4'h0;
        end else if (sym_tick && sym_cnt != 4'hf) begin
            sym_cnt <= sym_cnt + 4'h1;
        end
    end

    // Per-frame timing choice, latched at frame end
    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            target_sym <= `AAR_STD_ACK_SYM;
            frame_slotted <= 1'b0;
        end else if (take_end) begin
            frame_slotted <= slotted_en;
            if (short_ack_delay_sel) begin
                target_sym <= `AAR_SHORT_ACK_SYM;
            end else begin
                target_sym <= `AAR_STD_ACK_SYM;
            end
        end
    end

    // Trigger capture; early edges before two symbols are ignored
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || state != ST_WAIT_TRIG) begin
            trig_seen <= 1'b0;
            trig_cnt <= 16'h0000;
        end else if (!trig_seen) begin
            if (trig_edge && sym_cnt >= `AAR_TRIG_MIN_SYM) begin
                trig_seen <= 1'b1;
                trig_cnt <= 16'h0000;
            end
        end else if (trig_cnt != to16(TRIG_CYCLES - 1)) begin
            trig_cnt <= trig_cnt + 16'h0001;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST || state != ST_WAIT_TRIG) begin
            ACK_READY <= 1'b0;
        end else if (sym_tick && sym_cnt == `AAR_READY_SYM - 4'h1) begin
            ACK_READY <= 1'b1;
        end
    end

    always_comb begin
        launch = 1'b0;
        case (state)
            ST_DELAY: launch = sym_tick && (sym_cnt == target_sym - 4'h1);
            ST_WAIT_TRIG: begin
                launch = trig_seen && ACK_READY && (trig_cnt == to16(TRIG_CYCLES - 1));
            end
            default: launch = 1'b0;
        endcase
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE, ST_RX: begin
                if (take_end) begin
                    if (accept && ack_now) begin
                        next_state = slotted_en ? ST_WAIT_TRIG : ST_DELAY;
                    end else begin
                        next_state = ST_IDLE;
                    end
                end else if (RX_START && AUTO_ACK_RECEIVE_MODE) begin
                    next_state = ST_RX;
                end
            end
            ST_DELAY, ST_WAIT_TRIG: begin
                if (launch) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            ACK_TX_START <= 1'b0;
            AUTO_ACK_RX_BUSY <= 1'b0;
        end else begin
            ACK_TX_START <= launch;
            AUTO_ACK_RX_BUSY <= (next_state == ST_RX);
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            TRANSACTION_RESULT <= `AAR_RES_SUCCESS;
        end else if (next_state == ST_WAIT_TRIG) begin
            TRANSACTION_RESULT <= `AAR_RES_WAIT_TRIG;
        end else if (launch) begin
            TRANSACTION_RESULT <= `AAR_RES_SUCCESS;
        end
    end

    // Checking helpers: cycles since frame end and since last trigger edge seen while waiting
    logic [31:0] since_end;
    logic [31:0] since_trig;
    logic unfilt;
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || take_end) begin
            since_end <= 32'h0;
        end else if (since_end != 32'hffffffff) begin
            since_end <= since_end + 32'h1;
        end
    end
    always_ff @(posedge CLOCK) begin
        if (SYS_RST || (state == ST_WAIT_TRIG && !trig_seen && trig_edge)) begin
            since_trig <= 32'h0;
        end else if (since_trig != 32'hffffffff) begin
            since_trig <= since_trig + 32'h1;
        end
    end
    assign unfilt = reserved_type_upload_en && !reserved_type_filter_en;

    sequence s_unfilt_end;
        take_end && RX_INFO.reserved_type && unfilt;
    endsequence

    sequence s_filt_end;
        take_end && RX_INFO.reserved_type && reserved_type_upload_en && reserved_type_filter_en;
    endsequence

    sequence s_slot_launch;
        ACK_TX_START && frame_slotted;
    endsequence

    a_unfilt_done: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_unfilt_end |=> FRAME_DONE_EVENT == $past(RX_INFO.crc_ok))
        else $error("unfiltered reserved frame end wrong");

    a_unfilt_no_ack: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_unfilt_end |=> !ADDR_MATCH_EVENT && state == ST_IDLE)
        else $error("unfiltered reserved frame matched or acked");

    a_filt_match: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_filt_end |=> ADDR_MATCH_EVENT == $past(RX_INFO.addr_match))
        else $error("filtered reserved frame match wrong");

    a_filt_done: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_filt_end |=> FRAME_DONE_EVENT == $past(RX_INFO.addr_match && RX_INFO.crc_ok))
        else $error("filtered reserved frame end wrong");

    a_filt_ack: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_filt_end ##1 (state != ST_IDLE) |-> FRAME_DONE_EVENT && $past(RX_INFO.ack_request))
        else $error("ack pending without request or frame end");

    a_discard_silent: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        take_end && RX_INFO.reserved_type && !reserved_type_upload_en
        |=> !FRAME_DONE_EVENT && !ADDR_MATCH_EVENT && state == ST_IDLE)
        else $error("discarded reserved frame produced activity");

    a_std_delay: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ACK_TX_START && !frame_slotted && target_sym == `AAR_STD_ACK_SYM
        |-> since_end == 32'(12 * SYM_CYCLES))
        else $error("standard ack delay wrong");

    a_short_delay: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        ACK_TX_START && !frame_slotted && target_sym == `AAR_SHORT_ACK_SYM
        |-> since_end == 32'(2 * SYM_CYCLES))
        else $error("short ack delay wrong");

    a_wait_result: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        state == ST_WAIT_TRIG |-> TRANSACTION_RESULT == `AAR_RES_WAIT_TRIG)
        else $error("wait code missing while trigger pending");

    a_ready_time: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        $rose(ACK_READY) |-> since_end == 32'(3 * SYM_CYCLES))
        else $error("ack ready time wrong");

    a_trig_delay: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        s_slot_launch |-> since_trig >= 32'(TRIG_CYCLES) && $past(trig_seen))
        else $error("slotted ack started before trigger delay");

endmodule : aar_rx
